// >>> core/scp_defines.vh
// constants for the serial command and print port
`ifndef SCP_DEFINES_VH
`define SCP_DEFINES_VH
// register byte offsets
`define SCP_REG_CTRL 8'h00
`define SCP_REG_INTERVAL 8'h04
`define SCP_REG_HARM 8'h08
`define SCP_REG_TXDATA 8'h0c
`define SCP_REG_STATUS 8'h10
`define SCP_REG_LINE 8'h14
`define SCP_REG_DONE 8'h18
// control fields
`define SCP_CTRL_EN 0
`define SCP_CTRL_CMD 1
`define SCP_CTRL_ECHO_OFF 2
`define SCP_CTRL_PIN_PRN 3
`define SCP_CTRL_INT_PRN 4
`define SCP_CTRL_BAUD_LSB 5
`define SCP_CTRL_BAUD_MSB 7
`define SCP_CTRL_RST 8'h80
// harmonic fields
`define SCP_HARM_ODD 8
`define SCP_HARM_VOLT 9
`define SCP_HARM_AMP 10
`define SCP_HARM_PWR 11
`define SCP_HARM_MAX_RST 7'h01
`define SCP_HARM_MAX_LIM 7'h63
// character framing
`define SCP_DATA_BITS 8
`define SCP_STOP_BITS 2
`define SCP_CHAR_CR 8'h0d
`define SCP_CHAR_PROMPT 8'h3e
// baud selector codes
`define SCP_BAUD_19200 3'h4
// timing
`define SCP_CLK_HZ 100000000
`define SCP_MINUTE_S 60
`endif

// >>> core/scp_port.v
// serial command / print port: uart framing, rts/cts, echo, line buffer, print triggers
//
// The register addresses and the plain strobed port are this design's own decisions.
`include "scp_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module scp_port #(
  parameter LINE_DEPTH = 64,
  parameter LINE_AW = 6,
  parameter [39:0] MINUTE_CYCLES = `SCP_CLK_HZ * 40'd60
) (
  // clock, reset, enable
  input wire sys_clk_i,
  input wire srst_i,
  input wire ce_i,
  // register port
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  // serial pins
  input wire rxd_i,
  output wire txd_o,
  input wire cts_n_i,
  output wire rts_n_o,
  // print trigger pins
  input wire print_key_i,
  input wire ext_trig_n_i,
  // print and harmonic outputs, harmonic order input
  output reg print_start_o,
  output wire print_to_parallel_o,
  output wire harm_pct_and_abs_o,
  output wire [6:0] harm_max_o,
  output wire harm_odd_only_o,
  output wire harm_power_o,
  input wire [6:0] harm_order_i,
  output wire harm_include_o,
  output wire remote_led_o
);
  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA = 2'h2;
  localparam RX_STOP = 2'h3;

  // cycles per bit for each selector code; 19200 is code 4
  // 17 bits because 1200 baud needs more than 65535 cycles per bit
  function [16:0] baud_div;
    input [2:0] sel;
    reg [31:0] d;
    begin
      case (sel)
        3'h0: d = `SCP_CLK_HZ / 1200;
        3'h1: d = `SCP_CLK_HZ / 2400;
        3'h2: d = `SCP_CLK_HZ / 4800;
        3'h3: d = `SCP_CLK_HZ / 9600;
        3'h4: d = `SCP_CLK_HZ / 19200;
        3'h5: d = `SCP_CLK_HZ / 38400;
        3'h6: d = `SCP_CLK_HZ / 57600;
        default: d = `SCP_CLK_HZ / 115200;
      endcase
      baud_div = d[16:0];
    end
  endfunction

  // registers
  reg [7:0] ctrl_q;
  reg [15:0] interval_q;
  reg [6:0] harm_max_q;
  reg harm_odd_q, harm_volt_q, harm_amp_q, harm_pwr_q;
  reg remote_q;
  // pin synchronisers
  reg [1:0] rxd_s_q, cts_s_q, key_s_q, trig_s_q;
  reg key_prev_q, trig_prev_q;
  // receiver
  reg [1:0] rx_st_q;
  reg [16:0] rx_cnt_q;
  reg [2:0] rx_bit_q;
  reg [7:0] rx_sh_q;
  // line buffer
  reg [7:0] line_mem_q [0:LINE_DEPTH-1];
  reg [LINE_AW:0] line_cnt_q;
  reg [LINE_AW-1:0] line_rd_q;
  reg line_ready_q;
  // transmit sources and shifter
  reg echo_pend_q;
  reg [7:0] echo_q;
  reg sw_pend_q;
  reg [7:0] sw_q;
  reg prompt_pend_q;
  reg [10:0] tx_sh_q;
  reg [3:0] tx_bits_q;
  reg [16:0] tx_cnt_q;
  reg txd_q;
  // interval timer
  reg [39:0] min_cnt_q;
  reg [15:0] int_cnt_q;

  wire [16:0] bit_div = baud_div(ctrl_q[`SCP_CTRL_BAUD_MSB:`SCP_CTRL_BAUD_LSB]);
  wire [15:0] int_minutes = {8'h00, interval_q[15:8]} * 16'd60 + {8'h00, interval_q[7:0]};
  wire port_en = ctrl_q[`SCP_CTRL_EN];
  wire cmd_mode = port_en & ctrl_q[`SCP_CTRL_CMD];
  wire prn_mode = port_en & ~ctrl_q[`SCP_CTRL_CMD];
  wire wr_ok = ce_i & reg_wr_i;
  wire rd_ok = ce_i & reg_rd_i;
  wire rx_done = ce_i & (rx_st_q == RX_STOP) & (rx_cnt_q == 17'h00000) & rxd_s_q[1];
  wire line_full = (line_cnt_q == LINE_DEPTH[LINE_AW:0]);
  wire tx_idle = (tx_bits_q == 4'h0);
  wire line_pop = rd_ok & (reg_addr_i == `SCP_REG_LINE) & line_ready_q;
  wire done_wr = wr_ok & (reg_addr_i == `SCP_REG_DONE) & line_ready_q;
  wire sw_wr = wr_ok & (reg_addr_i == `SCP_REG_TXDATA) & ~sw_pend_q;

  // rts drops two slots early so characters already on the wire still fit
  assign rts_n_o = ~(cmd_mode & ~line_ready_q &
                     (line_cnt_q < LINE_DEPTH[LINE_AW:0] - {{LINE_AW-1{1'b0}}, 2'h2}));
  assign txd_o = txd_q;
  assign print_to_parallel_o = ~prn_mode;
  assign harm_pct_and_abs_o = 1'b1;
  assign harm_max_o = harm_max_q;
  assign harm_odd_only_o = harm_odd_q;
  assign harm_power_o = harm_pwr_q;
  assign harm_include_o = (harm_order_i != 7'h00) & (harm_order_i <= harm_max_q) &
                          (~harm_odd_q | harm_order_i[0]);
  assign remote_led_o = remote_q;

  // two-flop synchronisers on every pin input
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      rxd_s_q <= 2'h3;
      cts_s_q <= 2'h3;
      key_s_q <= 2'h0;
      trig_s_q <= 2'h3;
    end else if (ce_i) begin
      rxd_s_q <= {rxd_s_q[0], rxd_i};
      cts_s_q <= {cts_s_q[0], cts_n_i};
      key_s_q <= {key_s_q[0], print_key_i};
      trig_s_q <= {trig_s_q[0], ext_trig_n_i};
    end
  end

  // configuration registers
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      ctrl_q <= `SCP_CTRL_RST;
      interval_q <= 16'h0000;
      harm_max_q <= `SCP_HARM_MAX_RST;
      harm_odd_q <= 1'b0;
      harm_volt_q <= 1'b0;
      harm_amp_q <= 1'b0;
      harm_pwr_q <= 1'b0;
    end else if (wr_ok) begin
      case (reg_addr_i)
        `SCP_REG_CTRL: ctrl_q <= reg_wdata_i[7:0];
        `SCP_REG_INTERVAL: interval_q <= reg_wdata_i[15:0];
        `SCP_REG_HARM: begin
          // out-of-range orders clamp into 1..99
          if (reg_wdata_i[6:0] == 7'h00)
            harm_max_q <= 7'h01;
          else if (reg_wdata_i[6:0] > `SCP_HARM_MAX_LIM)
            harm_max_q <= `SCP_HARM_MAX_LIM;
          else
            harm_max_q <= reg_wdata_i[6:0];
          harm_odd_q <= reg_wdata_i[`SCP_HARM_ODD];
          harm_volt_q <= reg_wdata_i[`SCP_HARM_VOLT];
          harm_amp_q <= reg_wdata_i[`SCP_HARM_AMP];
          harm_pwr_q <= reg_wdata_i[`SCP_HARM_PWR] & reg_wdata_i[`SCP_HARM_VOLT] &
                        reg_wdata_i[`SCP_HARM_AMP];
        end
        default: ;
      endcase
    end
  end

  // receiver: centre-of-bit sampling, one stop bit checked
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= 17'h00000;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
    end else if (ce_i) begin
      case (rx_st_q)
        RX_IDLE: begin
          if (~rxd_s_q[1] & port_en) begin
            rx_st_q <= RX_START;
            rx_cnt_q <= {1'b0, bit_div[16:1]};
          end
        end
        RX_START: begin
          if (rx_cnt_q != 17'h00000)
            rx_cnt_q <= rx_cnt_q - 17'h00001;
          else if (rxd_s_q[1])
            rx_st_q <= RX_IDLE;
          else begin
            rx_st_q <= RX_DATA;
            rx_cnt_q <= bit_div - 17'h00001;
            rx_bit_q <= 3'h0;
          end
        end
        RX_DATA: begin
          if (rx_cnt_q != 17'h00000)
            rx_cnt_q <= rx_cnt_q - 17'h00001;
          else begin
            rx_sh_q <= {rxd_s_q[1], rx_sh_q[7:1]};
            rx_cnt_q <= bit_div - 17'h00001;
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'h7)
              rx_st_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_cnt_q != 17'h00000)
            rx_cnt_q <= rx_cnt_q - 17'h00001;
          else
            rx_st_q <= RX_IDLE;
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // line buffer and command hand-off
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      line_cnt_q <= {(LINE_AW+1){1'b0}};
      line_rd_q <= {LINE_AW{1'b0}};
      line_ready_q <= 1'b0;
      remote_q <= 1'b0;
    end else if (ce_i) begin
      if (done_wr) begin
        line_ready_q <= 1'b0;
        line_cnt_q <= {(LINE_AW+1){1'b0}};
        line_rd_q <= {LINE_AW{1'b0}};
      end else if (rx_done & cmd_mode & ~line_ready_q) begin
        if (rx_sh_q == `SCP_CHAR_CR) begin
          line_ready_q <= 1'b1;
          line_rd_q <= {LINE_AW{1'b0}};
          remote_q <= 1'b1;
        end else if (~line_full) begin
          line_cnt_q <= line_cnt_q + {{LINE_AW{1'b0}}, 1'b1};
        end
      end else if (line_pop) begin
        line_rd_q <= line_rd_q + {{(LINE_AW-1){1'b0}}, 1'b1};
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < LINE_DEPTH; gi = gi + 1) begin : g_line
      localparam [LINE_AW-1:0] SLOT = gi;
      always @(posedge sys_clk_i) begin
        if (srst_i)
          line_mem_q[gi] <= 8'h00;
        else if (ce_i & rx_done & cmd_mode & ~line_ready_q & ~line_full &
                 (rx_sh_q != `SCP_CHAR_CR) & (line_cnt_q[LINE_AW-1:0] == SLOT))
          line_mem_q[gi] <= rx_sh_q;
      end
    end
  endgenerate

  // transmit arbitration: echo first, then reply data, prompt only once reply drained
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      echo_pend_q <= 1'b0;
      echo_q <= 8'h00;
      sw_pend_q <= 1'b0;
      sw_q <= 8'h00;
      prompt_pend_q <= 1'b0;
      tx_sh_q <= 11'h7ff;
      tx_bits_q <= 4'h0;
      tx_cnt_q <= 17'h00000;
      txd_q <= 1'b1;
    end else if (ce_i) begin
      if (rx_done & cmd_mode & ~ctrl_q[`SCP_CTRL_ECHO_OFF]) begin
        echo_pend_q <= 1'b1;
        echo_q <= rx_sh_q;
      end
      if (sw_wr) begin
        sw_pend_q <= 1'b1;
        sw_q <= reg_wdata_i[7:0];
      end
      if (done_wr)
        prompt_pend_q <= 1'b1;
      if (~tx_idle) begin
        if (tx_cnt_q != 17'h00000)
          tx_cnt_q <= tx_cnt_q - 17'h00001;
        else begin
          txd_q <= tx_sh_q[0];
          tx_sh_q <= {1'b1, tx_sh_q[10:1]};
          tx_cnt_q <= bit_div - 17'h00001;
          tx_bits_q <= tx_bits_q - 4'h1;
        end
      end else if (~cts_s_q[1] & port_en) begin
        // a new character starts only while the partner grants cts
        // twelve steps: the last one closes a full second stop bit before the next start
        if (echo_pend_q) begin
          tx_sh_q <= {2'h3, echo_q, 1'b0};
          tx_bits_q <= 4'd12;
          tx_cnt_q <= 17'h00000;
          echo_pend_q <= 1'b0;
        end else if (sw_pend_q) begin
          tx_sh_q <= {2'h3, sw_q, 1'b0};
          tx_bits_q <= 4'd12;
          tx_cnt_q <= 17'h00000;
          sw_pend_q <= 1'b0;
        end else if (prompt_pend_q & ~done_wr) begin
          tx_sh_q <= {2'h3, `SCP_CHAR_PROMPT, 1'b0};
          tx_bits_q <= 4'd12;
          tx_cnt_q <= 17'h00000;
          prompt_pend_q <= 1'b0;
        end
      end
    end
  end

  // print triggers: key, grounded pin, interval timer
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      key_prev_q <= 1'b0;
      trig_prev_q <= 1'b1;
      min_cnt_q <= 40'h0000000000;
      int_cnt_q <= 16'h0000;
      print_start_o <= 1'b0;
    end else if (ce_i) begin
      key_prev_q <= key_s_q[1];
      trig_prev_q <= trig_s_q[1];
      print_start_o <= 1'b0;
      if (key_s_q[1] & ~key_prev_q & ~ctrl_q[`SCP_CTRL_PIN_PRN])
        print_start_o <= 1'b1;
      if (~trig_s_q[1] & trig_prev_q & ctrl_q[`SCP_CTRL_PIN_PRN])
        print_start_o <= 1'b1;
      if (~ctrl_q[`SCP_CTRL_INT_PRN] | (interval_q == 16'h0000)) begin
        min_cnt_q <= 40'h0000000000;
        int_cnt_q <= 16'h0000;
      end else if (min_cnt_q != MINUTE_CYCLES - 40'h0000000001) begin
        min_cnt_q <= min_cnt_q + 40'h0000000001;
      end else begin
        min_cnt_q <= 40'h0000000000;
        // interval holds hours in the upper byte, minutes in the lower
        if (int_cnt_q + 16'h0001 >= int_minutes) begin
          int_cnt_q <= 16'h0000;
          print_start_o <= 1'b1;
        end else begin
          int_cnt_q <= int_cnt_q + 16'h0001;
        end
      end
    end
  end

  // read port: data stands the cycle after the strobe
  always @(posedge sys_clk_i) begin
    if (srst_i)
      reg_rdata_o <= 32'h00000000;
    else if (rd_ok) begin
      case (reg_addr_i)
        `SCP_REG_CTRL: reg_rdata_o <= {24'h000000, ctrl_q};
        `SCP_REG_INTERVAL: reg_rdata_o <= {16'h0000, interval_q};
        `SCP_REG_HARM: reg_rdata_o <= {20'h00000, harm_pwr_q, harm_amp_q, harm_volt_q, harm_odd_q,
                                       1'b0, harm_max_q};
        `SCP_REG_STATUS: reg_rdata_o <= {16'h0000, {(8-LINE_AW-1){1'b0}}, line_cnt_q, 3'h0,
                                         ~rts_n_o, prn_mode, remote_q, ~tx_idle | sw_pend_q, line_ready_q};
        `SCP_REG_LINE: reg_rdata_o <= {24'h000000, line_mem_q[line_rd_q]};
        default: reg_rdata_o <= 32'h00000000;
      endcase
    end
  end
endmodule // scp_port
`default_nettype wire

// >>> tb/scp_port_chk.sv
// assertion checker for the serial command and print port
`timescale 1ns/1ps
`default_nettype none
module scp_port_chk (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // serial pins
  input wire logic txd_o,
  input wire logic cts_n_i,
  input wire logic rts_n_o,
  // print and harmonic pins
  input wire logic print_start_o,
  input wire logic print_to_parallel_o,
  input wire logic harm_pct_and_abs_o,
  input wire logic [6:0] harm_max_o,
  input wire logic harm_odd_only_o,
  input wire logic [6:0] harm_order_i,
  input wire logic harm_include_o,
  input wire logic remote_led_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // six cycles cover the two sync stages plus the start decision
  sequence cts_held_off;
    cts_n_i [*6];
  endsequence
  sequence tx_start;
    $fell(txd_o);
  endsequence
  a_tx_waits_cts: assert property (cts_held_off |-> not tx_start)
    else $error("tx frame began while cts off");
  a_print_one_cycle: assert property (print_start_o |=> !print_start_o)
    else $error("print start longer than one cycle");
  a_remote_stays_lit: assert property (remote_led_o |=> remote_led_o)
    else $error("remote indicator dropped");
  a_harm_max_range: assert property (harm_max_o >= 7'h01 && harm_max_o <= 7'h63)
    else $error("harmonic order limit out of range");
  a_harm_order_pick: assert property (harm_include_o == (harm_order_i != 7'h00 &&
    harm_order_i <= harm_max_o && (!harm_odd_only_o || harm_order_i[0])))
    else $error("harmonic include wrong");
  a_pct_and_abs: assert property (harm_pct_and_abs_o)
    else $error("percent and absolute flag low");
  a_printer_no_rts: assert property (!print_to_parallel_o |-> rts_n_o)
    else $error("rts asserted in printer mode");
  a_reset_state: assert property (disable iff (1'b0) srst_i |=> txd_o && rts_n_o &&
    !print_start_o && !remote_led_o && print_to_parallel_o && harm_max_o == 7'h01)
    else $error("outputs wrong after reset");
endmodule // scp_port_chk
bind scp_port scp_port_chk chk_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .txd_o(txd_o),
  .cts_n_i(cts_n_i), .rts_n_o(rts_n_o), .print_start_o(print_start_o),
  .print_to_parallel_o(print_to_parallel_o), .harm_pct_and_abs_o(harm_pct_and_abs_o),
  .harm_max_o(harm_max_o), .harm_odd_only_o(harm_odd_only_o), .harm_order_i(harm_order_i),
  .harm_include_o(harm_include_o), .remote_led_o(remote_led_o));
`default_nettype wire

// >>> tb/scp_host_model.sv
// serial host model: frames bytes to the device and collects what it sends
`timescale 1ns/1ps
`default_nettype none
module scp_host_model #(
  parameter int BIT_CYC = 868
) (
  // clock
  input wire logic clk,
  // serial pins
  input wire logic txd,
  input wire logic rts_n,
  input wire logic stall,
  output logic rxd,
  output logic cts_n
);
  logic [7:0] rx_q[$];
  logic [7:0] rb;
  int frame_errs = 0;
  assign cts_n = stall;
  initial rxd = 1'b1;
  // waits for rts before each frame since the device may be busy
  task automatic send(input logic [7:0] b);
    logic [10:0] f;
    f = {2'b11, b, 1'b0};
    while (rts_n) @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask
  always begin
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge clk);
    if (txd !== 1'b0) frame_errs++;
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      if (i < 8) rb[i] = txd;
      else if (txd !== 1'b1) frame_errs++;
    end
    rx_q.push_back(rb);
  end
endmodule // scp_host_model
`default_nettype wire

// >>> tb/scp_port_test.sv
// testbench for the serial command and print port
`include "scp_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module scp_port_test;
  localparam int BIT = 868; // 115200 baud at 100 MHz
  logic sys_clk, srst, wr, rd, key, trig_n, stall;
  logic [7:0] addr;
  logic [31:0] wdata, v;
  logic [6:0] order;
  wire logic txd, rxd, cts_n, rts_n, prn, par, pct, odd, pwr, incl, led;
  wire logic [6:0] hmax;
  wire logic [31:0] rdata;
  int n_errors = 0;
  int checks = 0;
  int n;
  // a one minute interval of 100 cycles keeps timed prints short
  scp_port #(.LINE_DEPTH(8), .LINE_AW(3), .MINUTE_CYCLES(40'd100)) dut_u (.sys_clk_i(sys_clk),
    .srst_i(srst), .ce_i(1'b1), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .rxd_i(rxd), .txd_o(txd), .cts_n_i(cts_n),
    .rts_n_o(rts_n), .print_key_i(key), .ext_trig_n_i(trig_n), .print_start_o(prn),
    .print_to_parallel_o(par), .harm_pct_and_abs_o(pct), .harm_max_o(hmax),
    .harm_odd_only_o(odd), .harm_power_o(pwr), .harm_order_i(order),
    .harm_include_o(incl), .remote_led_o(led));
  scp_host_model #(.BIT_CYC(BIT)) host_u (.clk(sys_clk), .txd(txd), .rts_n(rts_n),
    .stall(stall), .rxd(rxd), .cts_n(cts_n));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic count_prn(input int cyc, output int c);
    c = 0;
    repeat (cyc) begin
      @(posedge sys_clk);
      #1 if (prn === 1'b1) c++;
    end
  endtask
  task automatic rx_chk(input logic [7:0] exp);
    int t;
    t = 0;
    while (host_u.rx_q.size() == 0 && t < 33 * BIT) begin
      @(posedge sys_clk);
      t++;
    end
    if (host_u.rx_q.size() == 0) chk("serial byte", exp, 32'hffffffff);
    else chk("serial byte", exp, host_u.rx_q.pop_front());
  endtask
  task automatic results;
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    results();
  end
  initial begin
    {srst, stall, trig_n} = 3'b111;
    {wr, rd, key} = 3'b000;
    addr = 8'h00;
    wdata = 32'h0;
    order = 7'h00;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    rd_reg(`SCP_REG_CTRL, v);
    chk("ctrl reset", 32'h80, v);
    chk("parallel route", 32'h1, par);
    rd_reg(8'h1c, v);
    chk("unmapped read", 32'h0, v);
    wr_reg(`SCP_REG_HARM, 32'h800);
    chk("max floor", 32'h1, hmax);
    chk("power alone", 32'h0, pwr);
    wr_reg(`SCP_REG_HARM, 32'h7f);
    chk("max ceiling", 32'h63, hmax);
    wr_reg(`SCP_REG_HARM, 32'hf05);
    chk("power with both", 32'h1, pwr);
    chk("odd only", 32'h1, odd);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk) order <= 7'(i);
      #1 chk("include", (i % 2 == 1 && i <= 5), incl);
    end
    wr_reg(`SCP_REG_CTRL, 32'he1);
    chk("serial printer route", 32'h0, par);
    chk("rts in printer mode", 32'h1, rts_n);
    @(posedge sys_clk) key <= 1'b1;
    count_prn(12, n);
    chk("key print", 32'h1, n);
    @(posedge sys_clk) key <= 1'b0;
    wr_reg(`SCP_REG_CTRL, 32'he9);
    @(posedge sys_clk) trig_n <= 1'b0;
    count_prn(12, n);
    chk("pin print", 32'h1, n);
    @(posedge sys_clk) trig_n <= 1'b1;
    wr_reg(`SCP_REG_INTERVAL, 32'h1);
    wr_reg(`SCP_REG_CTRL, 32'hf1);
    count_prn(150, n);
    chk("interval print", 32'h1, n);
    @(posedge sys_clk) key <= 1'b1;
    count_prn(100, n);
    chk("interval and key", 32'h2, n);
    @(posedge sys_clk) key <= 1'b0;
    wr_reg(`SCP_REG_INTERVAL, 32'h0);
    wr_reg(`SCP_REG_CTRL, 32'he3);
    @(posedge sys_clk) stall <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("rts ready", 32'h0, rts_n);
    host_u.send(8'h41);
    rx_chk(8'h41);
    host_u.send(`SCP_CHAR_CR);
    rx_chk(`SCP_CHAR_CR);
    rd_reg(`SCP_REG_STATUS, v);
    chk("line ready", 32'h1, v[0]);
    chk("rts busy", 32'h1, rts_n);
    chk("remote led", 32'h1, led);
    rd_reg(`SCP_REG_LINE, v);
    chk("line byte", 32'h41, v);
    @(posedge sys_clk) stall <= 1'b1;
    wr_reg(`SCP_REG_TXDATA, 32'h4b);
    wr_reg(`SCP_REG_DONE, 32'h0);
    repeat (200) @(posedge sys_clk);
    chk("tx held by cts", 32'h1, txd);
    @(posedge sys_clk) stall <= 1'b0;
    rx_chk(8'h4b);
    rx_chk(`SCP_CHAR_PROMPT);
    wr_reg(`SCP_REG_CTRL, 32'he7);
    host_u.send(`SCP_CHAR_CR);
    wr_reg(`SCP_REG_DONE, 32'h0);
    rx_chk(`SCP_CHAR_PROMPT);
    chk("frame errors", 32'h0, host_u.frame_errs);
    results();
  end
endmodule // scp_port_test
`default_nettype wire
